// >>> hw/ufdps_top.sv
// user flash data page sequencer: register file, command engine, stall
// assumes an 8-bit core that honours core_stall_q and keeps its timers going
//
// What this block does
// RULE_01: data array is 640 bytes, 160 four-byte pages, numbered 00h to 9fh.
// RULE_02: an 8-bit page address register selects the page for every command; command 06h ignores it and steps sweep_q through all pages.
// RULE_03: four byte registers hold read data or data to program or verify.
// RULE_04: command 01h copies the addressed page into the four data registers.
// RULE_05: command 02h programs the data registers into the addressed page.
// RULE_06: programming only clears bits; stored value becomes old AND new.
// RULE_07: command 04h compares; command register reads zero on match, nonzero otherwise.
// RULE_08: command 05h erases only the addressed four-byte page.
// RULE_09: command 06h erases all 160 pages in one operation.
// RULE_10: codes 03h and 07h through ffh are reserved and must not be issued.
// RULE_11: page erase and whole-array erase each last 20 ms.
// RULE_12: programming a page lasts 250 us.
// RULE_13: a page read completes within one instruction cycle.
// RULE_14: an operation starts as soon as its code is written.
// RULE_15: the core is held, and no interrupt taken, until the operation ends.
// RULE_16: counters and timers keep running while the core is held.
// RULE_17: erased bytes read ffh; the array starts out erased.
// RULE_18: software loads page address, then data, then writes the command.
// RULE_19: stall output rises on command write and falls when the duration expires.
// RULE_20: after non-verify commands the command register reads back the written value.

module ufdps_top #(
   parameter int ERASE_CYCLES_P = ufdps_pkg::ERASE_CYCLES,
   parameter int PROG_CYCLES_P = ufdps_pkg::PROG_CYCLES
) (
   // clock and reset
   input logic ref_clk,
   input logic rst,
   // special function register bus
   input ufdps_pkg::ufdps_sfr_req_type sfr_req,
   output logic [7:0] sfr_rdata_q,
   // core hold
   output logic core_stall_q
);
   import ufdps_pkg::*;

   // =======================================
   // state
   ufdps_state_type state_q, state_d;
   logic [7:0] cmd_q, cmd_d;
   logic [7:0] page_q, page_d;
   logic [PAGE_BYTES-1:0][7:0] data_q, data_d;
   logic [7:0] sweep_q, sweep_d;
   logic stall_d;
   logic [7:0] rdata_d;
   logic [31:0] mem_rdata;
   logic [TIMER_W-1:0] timer_cnt;
   ufdps_mem_req_type mem_req;

   function automatic logic sfr_hit(input ufdps_sfr_req_type r, input logic [7:0] a);
      sfr_hit = r.addr == a;
   endfunction

   // =======================================
   // register decode
   // writes while busy are dropped; the core cannot issue them anyway
   wire idle = state_q == ST_IDLE;
   wire wr_cmd = sfr_req.wr && idle && sfr_hit(sfr_req, ADDR_CMD);
   wire wr_page = sfr_req.wr && idle && sfr_hit(sfr_req, ADDR_PAGE);
   wire data_sel = sfr_req.addr[7:2] == ADDR_DATA0[7:2];
   wire wr_data = sfr_req.wr && idle && data_sel;
   wire [1:0] data_idx = sfr_req.addr[1:0];
   wire [7:0] code = sfr_req.wdata;
   wire is_read = code == CMD_READ;
   wire is_prog = code == CMD_PROG;
   wire is_verify = code == CMD_VERIFY;
   wire is_erase = code == CMD_ERASE;
   wire is_erase_all = code == CMD_ERASE_ALL;
   // reserved codes are stored but start nothing
   wire code_valid = is_read | is_prog | is_verify | is_erase | is_erase_all; // RULE_10
   wire cmd_go = wr_cmd && code_valid; // RULE_14
   wire [31:0] data_word = data_q;
   wire verify_match = mem_rdata == data_word;
   wire timer_start = cmd_go && (is_prog | is_erase | is_erase_all);
   wire [TIMER_W-1:0] erase_len = TIMER_W'(ERASE_CYCLES_P);
   wire [TIMER_W-1:0] prog_len = TIMER_W'(PROG_CYCLES_P);
   wire [TIMER_W-1:0] timer_load = is_prog ? prog_len : erase_len; // RULE_11 RULE_12
   wire timer_done = timer_cnt == TIMER_IDLE;

   // =======================================
   // array request
   wire sweeping = state_q == ST_SWEEP;
   wire erase_op = sweeping || cmd_q == CMD_ERASE;
   assign mem_req.we = sweeping || state_q == ST_WRITE;
   assign mem_req.addr = sweeping ? sweep_q : page_q; // RULE_02
   // program can only clear bits, so AND with what is stored
   assign mem_req.wdata = erase_op ? ERASED_WORD : (mem_rdata & data_word); // RULE_05 RULE_06 RULE_08 RULE_09

   // =======================================
   // next state
   always_comb begin
      state_d = state_q;
      stall_d = core_stall_q;
      cmd_d = cmd_q;
      sweep_d = sweep_q;
      case (state_q)
         ST_IDLE: begin
            if (wr_cmd) begin
               cmd_d = code; // RULE_20
            end
            if (cmd_go) begin
               stall_d = 1'b1; // RULE_15 RULE_19
               sweep_d = 8'h00;
               if (is_read) begin
                  state_d = ST_READ;
               end else if (is_verify) begin
                  state_d = ST_VERIFY;
               end else if (is_erase_all) begin
                  state_d = ST_SWEEP;
               end else begin
                  state_d = ST_WRITE;
               end
            end
         end
         ST_READ: begin
            // read data were fetched during the command cycle
            stall_d = 1'b0; // RULE_13
            state_d = ST_IDLE;
         end
         ST_VERIFY: begin
            if (verify_match) begin
               cmd_d = VERIFY_PASS; // RULE_07
            end
            stall_d = 1'b0;
            state_d = ST_IDLE;
         end
         ST_WRITE: begin
            state_d = ST_WAIT;
         end
         ST_SWEEP: begin
            // one page per cycle; 160 cycles fit well inside the erase time
            sweep_d = sweep_q + 8'h01;
            if (sweep_q == PAGE_LAST) begin
               state_d = ST_WAIT; // RULE_09
            end
         end
         ST_WAIT: begin
            if (timer_done) begin
               stall_d = 1'b0; // RULE_19
               state_d = ST_IDLE;
            end
         end
         default: begin
            stall_d = 1'b0;
            state_d = ST_IDLE;
         end
      endcase
   end

   // =======================================
   // page address and data registers
   assign page_d = wr_page ? sfr_req.wdata : page_q; // RULE_02

   generate
      for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_data
         assign data_d[i] = (state_q == ST_READ) ? mem_rdata[8*i +: 8] : // RULE_04
            (wr_data && data_idx == 2'(i)) ? sfr_req.wdata : data_q[i]; // RULE_03
      end
   endgenerate

   // =======================================
   // read mux
   assign rdata_d = !sfr_req.rd ? sfr_rdata_q :
      sfr_hit(sfr_req, ADDR_CMD) ? cmd_q :
      sfr_hit(sfr_req, ADDR_PAGE) ? page_q :
      data_sel ? data_q[data_idx] : UNMAPPED_READ;

   // =======================================
   // sequencer registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         core_stall_q <= 1'b0;
      end else begin
         state_q <= state_d;
         core_stall_q <= stall_d; // RULE_19
      end
   end

   // =======================================
   // command and page address registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_q <= CMD_RESET;
         page_q <= PAGE_RESET;
      end else begin
         cmd_q <= cmd_d;
         page_q <= page_d;
      end
   end

   // =======================================
   // page data registers and sweep pointer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         data_q <= {PAGE_BYTES{DATA_RESET}};
         sweep_q <= 8'h00;
      end else begin
         data_q <= data_d;
         sweep_q <= sweep_d;
      end
   end

   // =======================================
   // read data register
   // held between reads so a slow core can sample at leisure
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sfr_rdata_q <= 8'h00;
      end else begin
         sfr_rdata_q <= rdata_d;
      end
   end

   // =======================================
   // submodules
   // only the core is held; the clock never stops, so peripherals keep counting
   ufdps_timer #(
      .W(TIMER_W)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(timer_start),
      .load_val(timer_load),
      .cnt_q(timer_cnt)
   ); // RULE_16

   ufdps_mem #(
      .DEPTH(PAGE_COUNT)
   ) u_mem (
      .ref_clk(ref_clk),
      .mem_req(mem_req),
      .rdata_q(mem_rdata)
   ); // RULE_01

   // =======================================
   // checks
   logic [31:0] stall_cnt_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stall_cnt_q <= 32'h00000000;
      end else begin
         stall_cnt_q <= core_stall_q ? stall_cnt_q + 32'h00000001 : 32'h00000000;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_stall_on_cmd: assert property (cmd_go |=> core_stall_q) // RULE_19
      else $error("stall not raised after command");
   a_read_quick: assert property (cmd_go && is_read |-> ##2 !core_stall_q) // RULE_13
      else $error("page read held the core too long");
   a_read_loads: assert property (state_q == ST_READ |=> data_q == $past(mem_rdata)) // RULE_04
      else $error("page read did not load data registers");
   a_verify_result: assert property (state_q == ST_VERIFY |=>
      (cmd_q == VERIFY_PASS) == $past(verify_match)) // RULE_07
      else $error("verify result wrong");
   a_prog_and: assert property (mem_req.we && cmd_q == CMD_PROG |->
      (mem_req.wdata | mem_rdata) == mem_rdata) // RULE_06
      else $error("program set a bit");
   a_erase_page: assert property (mem_req.we && cmd_q == CMD_ERASE |->
      mem_req.addr == page_q && mem_req.wdata == ERASED_WORD) // RULE_08
      else $error("page erase wrong");
   a_sweep_span: assert property ($fell(sweeping) |-> $past(sweep_q) == PAGE_LAST) // RULE_09
      else $error("array erase sweep incomplete");
   a_erase_time: assert property ($fell(core_stall_q) &&
      (cmd_q == CMD_ERASE || cmd_q == CMD_ERASE_ALL) |-> stall_cnt_q >= ERASE_CYCLES_P) // RULE_11
      else $error("erase ended early");
   a_prog_time: assert property ($fell(core_stall_q) && cmd_q == CMD_PROG |->
      stall_cnt_q >= PROG_CYCLES_P) // RULE_12
      else $error("program ended early");
   a_reserved_idle: assert property (wr_cmd && !code_valid |=> !core_stall_q && idle) // RULE_10
      else $error("reserved code started an operation");
   a_cmd_readback: assert property (wr_cmd && !is_verify |=> ##1 cmd_q == $past(code, 2)) // RULE_20
      else $error("command register lost written value");
   a_busy_hold: assert property (!idle && state_q != ST_READ |=>
      $stable(page_q) && $stable(data_q)) // RULE_02
      else $error("page address changed while busy");

   // =======================================
   // register file checks
   a_rdata_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata_q)) // RULE_03
      else $error("read data changed without a read");
   a_page_write: assert property (wr_page |=> page_q == $past(sfr_req.wdata)) // RULE_02
      else $error("page address write lost");
   a_data_write: assert property (wr_data && data_idx == 2'd0 |=>
      data_q[0] == $past(sfr_req.wdata)) // RULE_03
      else $error("page data write lost");
   a_unmapped_read: assert property (sfr_req.rd && !data_sel &&
      !sfr_hit(sfr_req, ADDR_CMD) && !sfr_hit(sfr_req, ADDR_PAGE) |=>
      sfr_rdata_q == UNMAPPED_READ) // RULE_02
      else $error("unmapped read not zero");

   // =======================================
   // sequencer checks
   a_timer_load: assert property (timer_start |=> timer_cnt == $past(timer_load)) // RULE_12
      else $error("duration counter not loaded");
   a_stall_holds: assert property (state_q == ST_WAIT && !timer_done |=> core_stall_q) // RULE_15
      else $error("core released before operation end");
   a_idle_free: assert property (idle && !cmd_go |=> !core_stall_q) // RULE_19
      else $error("core held while idle");
   a_verify_fail: assert property (state_q == ST_VERIFY && !verify_match |=>
      cmd_q == CMD_VERIFY) // RULE_07
      else $error("verify mismatch not reported");
   a_sweep_word: assert property (mem_req.we && sweeping |->
      mem_req.wdata == ERASED_WORD) // RULE_09
      else $error("array erase wrote data");
   a_sweep_step: assert property (sweeping && sweep_q != PAGE_LAST |=>
      sweep_q == $past(sweep_q) + 8'h01) // RULE_09
      else $error("array erase skipped a page");
   a_read_nowrite: assert property (state_q == ST_READ |-> !mem_req.we) // RULE_04
      else $error("page read wrote the array");

   c_read: cover property (cmd_go && is_read ##2 !core_stall_q);
   c_verify_pass: cover property (state_q == ST_VERIFY && verify_match);
   c_prog_done: cover property (cmd_q == CMD_PROG && $fell(core_stall_q));
   c_erase_all_done: cover property (cmd_q == CMD_ERASE_ALL && $fell(core_stall_q));
   c_verify_fail: cover property (state_q == ST_VERIFY && !verify_match);

endmodule

// >>> hw/ufdps_pkg.sv
// constants and carrier types for the user flash data page sequencer
// assumes a 100 MHz ref_clk and an 8-bit special function register bus

package ufdps_pkg;

   // =======================================
   // array geometry
   localparam int PAGE_COUNT = 160;
   localparam logic [7:0] PAGE_LAST = 8'h9f;
   localparam int PAGE_BYTES = 4;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [31:0] ERASED_WORD = {PAGE_BYTES{ERASED_BYTE}};

   // =======================================
   // command codes
   localparam logic [7:0] CMD_READ = 8'h01;
   localparam logic [7:0] CMD_PROG = 8'h02;
   localparam logic [7:0] CMD_VERIFY = 8'h04;
   localparam logic [7:0] CMD_ERASE = 8'h05;
   localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
   localparam logic [7:0] VERIFY_PASS = 8'h00;

   // =======================================
   // register addresses and reset values
   localparam logic [7:0] ADDR_CMD = 8'hb9;
   localparam logic [7:0] ADDR_PAGE = 8'hc6;
   localparam logic [7:0] ADDR_DATA0 = 8'hbc;
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // =======================================
   // operation times
   localparam int CLK_PERIOD_NS = 10;
   localparam int ERASE_TIME_MS = 20;
   localparam int PROG_TIME_US = 250;
   localparam int ERASE_CYCLES = (ERASE_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int TIMER_W = 22;
   localparam logic [TIMER_W-1:0] TIMER_IDLE = 22'h000000;

   // =======================================
   // carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ufdps_sfr_req_type;

   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [31:0] wdata;
   } ufdps_mem_req_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_VERIFY,
      ST_WRITE,
      ST_SWEEP,
      ST_WAIT
   } ufdps_state_type;

endpackage

// >>> hw/ufdps_mem.sv
// page-wide data array, one word per page, registered read port
// assumes the sequencer decides what to write; no reset on the cells

module ufdps_mem #(
   parameter int DEPTH = 160
) (
   // clock
   input logic ref_clk,
   // access
   input ufdps_pkg::ufdps_mem_req_type mem_req,
   output logic [31:0] rdata_q
);
   import ufdps_pkg::*;

   localparam logic [7:0] DEPTH_B = 8'(DEPTH);

   logic [31:0] cells [DEPTH];
   wire addr_ok = mem_req.addr < DEPTH_B;

   // =======================================
   // delivered erased
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         cells[i] = ERASED_WORD; // RULE_17
      end
   end

   // =======================================
   // array
   // pages past the top are dropped on write and read back erased
   always_ff @(posedge ref_clk) begin
      if (mem_req.we && addr_ok) begin
         cells[mem_req.addr] <= mem_req.wdata; // RULE_01
      end
      rdata_q <= addr_ok ? cells[mem_req.addr] : ERASED_WORD;
   end

endmodule

// >>> hw/ufdps_timer.sv
// duration down-counter for program and erase operations
// assumes start is a one-cycle pulse; counts to zero and holds

module ufdps_timer #(
   parameter int W = 22
) (
   // clock and reset
   input logic ref_clk,
   input logic rst,
   // control
   input logic start,
   input logic [W-1:0] load_val,
   output logic [W-1:0] cnt_q
);
   import ufdps_pkg::*;

   wire [W-1:0] cnt_d = start ? load_val : (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;

   // =======================================
   // counter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// >>> bench/ufdps_core_model.sv
// core model: drives the register bus one strobe at a time
// assumes ufdps_top answers reads one cycle later and holds the core by stall
module ufdps_core_model (
   // clock
   input logic ref_clk,
   // register bus
   output ufdps_pkg::ufdps_sfr_req_type sfr_req,
   // core hold
   input logic core_stall_q
);
   timeunit 1ns;
   timeprecision 1ps;
   import ufdps_pkg::*;

   initial sfr_req = '0;

   // =======================================
   // bus cycles
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      sfr_req.wr <= 1'b0;
      // scrambled so a stale byte is never mistaken for a write
      sfr_req.wdata <= ~d;
   endtask

   task automatic sfr_read(input logic [7:0] a);
      @(posedge ref_clk);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      sfr_req.rd <= 1'b0;
   endtask

   // =======================================
   // command: issue, then stay held while stall is up
   task automatic command(input logic [7:0] code, output int n);
      sfr_write(ADDR_CMD, code);
      n = 0;
      @(posedge ref_clk);
      // no new instruction while held; bounded so a stuck stall ends
      while (core_stall_q === 1'b1 && n < 5000) begin
         n++;
         @(posedge ref_clk);
      end
   endtask
endmodule

// >>> bench/ufdps_tb_top.sv
// self-checking bench for the user flash data page sequencer
// assumes short operation counts; core model drives the register bus
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end

module ufdps_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ufdps_pkg::*;

   localparam int EC = 200;
   localparam int PC = 20;

   logic ref_clk;
   logic rst = 1'b1;
   ufdps_sfr_req_type sfr_req;
   logic [7:0] sfr_rdata_q;
   logic core_stall_q;
   int err_count = 0;
   int n_compared = 0;
   logic [7:0] exp_q[$];
   logic [7:0] e_v;
   logic rd_pend = 1'b0;
   logic [31:0] seed = 32'h6435;
   logic [31:0] w1;
   logic [31:0] w2;
   logic [7:0] rsv[4];
   logic [7:0] regs[7];

   // =======================================
   // clock, design and core model
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   ufdps_top #(.ERASE_CYCLES_P(EC), .PROG_CYCLES_P(PC)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .sfr_req(sfr_req),
      .sfr_rdata_q(sfr_rdata_q), .core_stall_q(core_stall_q));

   ufdps_core_model i_core (
      .ref_clk(ref_clk), .sfr_req(sfr_req), .core_stall_q(core_stall_q));

   // =======================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic summarize();
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_core.sfr_read(a);
   endtask

   task automatic page_op(input logic [7:0] p, input logic [31:0] w,
         input logic [7:0] c, input int st);
      int n;
      i_core.sfr_write(ADDR_PAGE, p);
      if (c == CMD_PROG || c == CMD_VERIFY) begin
         for (int i = 0; i < 4; i++) begin
            i_core.sfr_write(ADDR_DATA0 + 8'(i), w[8*i +: 8]);
         end
      end
      i_core.command(c, n);
      `CHK("stall cycles", st, n)
   endtask

   task automatic page_chk(input logic [7:0] p, input logic [31:0] e);
      page_op(p, 32'h0, CMD_READ, 1);
      for (int i = 0; i < 4; i++) begin
         rd_chk(ADDR_DATA0 + 8'(i), e[8*i +: 8]);
      end
   endtask

   // =======================================
   // result watcher: oldest note against the registered read data
   always @(posedge ref_clk) begin
      if (rd_pend) begin
         e_v = exp_q.pop_front();
         `CHK("sfr_rdata_q", e_v, sfr_rdata_q)
      end
      rd_pend = sfr_req.rd;
   end

   // =======================================
   // scenarios
   initial begin
      regs = '{ADDR_CMD, ADDR_PAGE, ADDR_DATA0, ADDR_DATA0 + 8'h01,
               ADDR_DATA0 + 8'h02, ADDR_DATA0 + 8'h03, 8'h01};
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      page_chk(8'h00, ERASED_WORD);
      rd_chk(ADDR_CMD, CMD_READ);
      w1 = rnd();
      w2 = rnd();
      page_op(8'h03, w1, CMD_PROG, PC + 1);
      rd_chk(ADDR_PAGE, 8'h03);
      rd_chk(ADDR_CMD, CMD_PROG);
      page_chk(8'h03, w1);
      page_op(8'h03, w2, CMD_PROG, PC + 1);
      page_chk(8'h03, w1 & w2);
      page_op(PAGE_LAST, w2, CMD_PROG, PC + 1);
      page_op(8'h03, w1 & w2, CMD_VERIFY, 1);
      rd_chk(ADDR_CMD, VERIFY_PASS);
      page_op(8'h03, ~(w1 & w2), CMD_VERIFY, 1);
      rd_chk(ADDR_CMD, CMD_VERIFY);
      page_op(8'h03, 32'h0, CMD_ERASE, EC + 1);
      page_chk(8'h03, ERASED_WORD);
      page_chk(PAGE_LAST, w2);
      page_op(8'h00, 32'h0, CMD_ERASE_ALL, EC + 1);
      page_chk(PAGE_LAST, ERASED_WORD);
      // reserved codes on purpose: they must start nothing
      rsv = '{8'h03, 8'h07, 8'hff, 8'(32'h7 + rnd() % 249)};
      foreach (rsv[i]) begin
         page_op(8'h03, 32'h0, rsv[i], 0);
         rd_chk(ADDR_CMD, rsv[i]);
      end
      repeat (3) @(posedge ref_clk);
      summarize();
   end

   // =======================================
   // watchdog: whole run needs well under a thousand cycles
   initial begin
      #200us;
      err_count++;
      summarize();
   end
endmodule
